// file: verilog/suspend_ctrl.sv
`timescale 1ns/1ps
module suspend_ctrl
	import susp_pkg::*;
#(
	parameter int CNT_W = 24,
	parameter int SUSP_LAT_CYC = SUSP_LAT_MAX_CYC,
	parameter logic [12:0] SUSPEND_SETTLE = 13'h0010,
	parameter logic [23:0] ERASE_CYCLES = 24'h001800,
	parameter logic [23:0] PROGRAM_CYCLES = 24'h000400
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic start_erase,
	input wire logic start_program,
	output logic busy,
	output logic erase_suspended,
	output logic program_suspended,
	output logic op_done,
	output logic [31:0] param_word
);
	// upper bound used by the latency checks below
	localparam int SETTLE_BOUND = 20;

	typedef enum logic [1:0] {
		st_idle,
		st_run,
		st_suspending,
		st_suspended
	} state_type;

	state_type state; // current phase of the array operation
	state_type next_state; // phase for the next edge
	logic is_erase; // running operation is an erase
	logic [12:0] settle; // cycles left to a safe stop point
	logic [CNT_W-1:0] remaining; // work left, frozen while suspended
	logic expired; // work finished

	// instruction decode from the serial front end, same clock
	wire is_suspend_cmd = cmd_valid && (cmd_code == CMD_SUSPEND);
	wire is_resume_cmd = cmd_valid && (cmd_code == CMD_RESUME);
	// starts only from idle, so nesting under a suspend is refused
	wire accept_start = (state == st_idle) &&
		(start_erase || start_program);
	wire take_suspend = (state == st_run) && is_suspend_cmd && !expired;
	wire finish = (state == st_run) && expired;
	wire take_resume = (state == st_suspended) && is_resume_cmd;
	// erase has priority if both starts arrive together
	wire [CNT_W-1:0] load_value = start_erase ?
		CNT_W'(ERASE_CYCLES) : CNT_W'(PROGRAM_CYCLES);
	// the work only moves in the run phase; the count is the resume point
	wire advance = (state == st_run);
	wire next_is_erase = accept_start ? start_erase : is_erase;

	// the word is assembled from named fields, never a magic number
	wire [31:0] next_param_word = {
		FLD_NO_SUSPEND,
		FLD_ERS_UNIT,
		FLD_ERS_CNT,
		FLD_ERS_GAP,
		FLD_PGM_UNIT,
		FLD_PGM_CNT,
		FLD_PGM_GAP,
		FLD_RFU,
		FLD_ERS_BAN,
		FLD_PGM_BAN
	};

	work_counter #(
		.CNT_W(CNT_W)
	) u_work (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(accept_start),
		.load_value(load_value),
		.advance(advance),
		.remaining(remaining),
		.expired(expired)
	);

	// phase sequencing; stray commands in other phases are ignored
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (accept_start) begin
					next_state = st_run;
				end
			end
			st_run: begin
				if (finish) begin
					next_state = st_idle;
				end else if (take_suspend) begin
					next_state = st_suspending;
				end
			end
			st_suspending: begin
				// settle is short of the 40 us ceiling by design
				if (settle == 13'h0000) begin
					next_state = st_suspended;
				end
			end
			st_suspended: begin
				if (take_resume) begin
					next_state = st_run;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	// phase and operation kind
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= st_idle;
			is_erase <= 1'b0;
		end else begin
			state <= next_state;
			is_erase <= next_is_erase;
		end
	end

	// stop-point countdown, loaded on the suspend request
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			settle <= 13'h0000;
		end else if (take_suspend) begin
			settle <= SUSPEND_SETTLE;
		end else if (settle != 13'h0000) begin
			settle <= settle - 13'h0001;
		end
	end

	// outputs straight from flops, aligned with the phase register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			erase_suspended <= 1'b0;
			program_suspended <= 1'b0;
			op_done <= 1'b0;
			param_word <= WORD_RESET;
		end else begin
			busy <= (next_state != st_idle);
			erase_suspended <= (next_state == st_suspended) &&
				next_is_erase;
			program_suspended <= (next_state == st_suspended) &&
				!next_is_erase;
			op_done <= finish;
			param_word <= next_param_word;
		end
	end

	// ---- checks ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// the suspend request as seen at the command port
	sequence erase_susp_req;
		state == st_run && is_erase && is_suspend_cmd && !expired;
	endsequence
	sequence prog_susp_req;
		state == st_run && !is_erase && is_suspend_cmd && !expired;
	endsequence
	sequence resume_req;
		state == st_suspended && is_resume_cmd;
	endsequence

	flag_bit_zero_a: assert property (
		$past(rst_b) |-> param_word[POS_NO_SUSPEND] == 1'b0)
		else $error("suspend flag bit not zero");
	unit_table_a: assert property (
		$past(rst_b) |-> unit_ns(param_word[POS_ERS_UNIT +: 2]) == 8000
		&& lat_ns(2'h0, 5'h00) == 128)
		else $error("latency unit encoding wrong");
	erase_latency_a: assert property (
		erase_susp_req |-> ##[1:SETTLE_BOUND] erase_suspended)
		else $error("erase suspend too slow");
	erase_field_a: assert property (
		$past(rst_b) |-> lat_ns(param_word[POS_ERS_UNIT +: 2],
		param_word[POS_ERS_CNT +: 5]) == SUSP_LAT_MAX_NS)
		else $error("erase latency field not 40 us");
	prog_latency_a: assert property (
		prog_susp_req |-> ##[1:SETTLE_BOUND] program_suspended)
		else $error("program suspend too slow");
	settle_fits_a: assert property (
		int'(settle) < SUSP_LAT_CYC)
		else $error("settle exceeds latency ceiling");
	gap_field_a: assert property (
		$past(rst_b) |-> gap_ns(param_word[POS_ERS_GAP +: 4]) ==
		RESUME_GAP_MIN_NS && gap_ns(param_word[POS_PGM_GAP +: 4]) ==
		RESUME_GAP_MIN_NS)
		else $error("resume gap field not 128 us");
	rfu_one_a: assert property (
		$past(rst_b) |-> param_word[POS_RFU] == 1'b1)
		else $error("bit 8 not one");
	resume_run_a: assert property (
		resume_req |=> state == st_run && busy && !erase_suspended
		&& !program_suspended)
		else $error("resume not taken");
	suspend_enter_a: assert property (
		prog_susp_req |=> state == st_suspending ##1 settle ==
		SUSPEND_SETTLE - 13'h0001)
		else $error("suspend not entered");
	work_frozen_a: assert property (
		state == st_suspended && !is_resume_cmd |=> $stable(remaining))
		else $error("work moved while suspended");
	resume_point_a: assert property (
		resume_req |=> remaining == $past(remaining))
		else $error("resume restarted the work");
endmodule // suspend_ctrl

// file: inc/susp_pkg.sv
package susp_pkg;
	// clock and timing, figures as printed
	localparam int CLK_PERIOD_NS = 8;
	localparam int SUSP_LAT_MAX_NS = 40000;
	// longest time rounds down to whole cycles
	localparam int SUSP_LAT_MAX_CYC = SUSP_LAT_MAX_NS / CLK_PERIOD_NS;
	localparam int RESUME_GAP_MIN_NS = 128000;
	localparam int INTERVAL_UNIT_NS = 64000;
	// instruction codes
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7A;
	// field positions in the suspend parameter word
	localparam int POS_NO_SUSPEND = 31;
	localparam int POS_ERS_UNIT = 29;
	localparam int POS_ERS_CNT = 24;
	localparam int POS_ERS_GAP = 20;
	localparam int POS_PGM_UNIT = 18;
	localparam int POS_PGM_CNT = 13;
	localparam int POS_PGM_GAP = 9;
	localparam int POS_RFU = 8;
	localparam int POS_ERS_BAN = 4;
	localparam int POS_PGM_BAN = 0;
	// field values
	localparam logic FLD_NO_SUSPEND = 1'h0;
	localparam logic [1:0] FLD_ERS_UNIT = 2'h2;
	localparam logic [4:0] FLD_ERS_CNT = 5'h04;
	localparam logic [3:0] FLD_ERS_GAP = 4'h1;
	localparam logic [1:0] FLD_PGM_UNIT = 2'h2;
	localparam logic [4:0] FLD_PGM_CNT = 5'h04;
	localparam logic [3:0] FLD_PGM_GAP = 4'h1;
	localparam logic FLD_RFU = 1'h1;
	localparam logic [3:0] FLD_ERS_BAN = 4'hC;
	localparam logic [3:0] FLD_PGM_BAN = 4'hC;
	// reset value of the registered word
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// latency unit table, in ns
	function automatic int unit_ns(input logic [1:0] code);
		case (code)
			2'h0: unit_ns = 128;
			2'h1: unit_ns = 1000;
			2'h2: unit_ns = 8000;
			default: unit_ns = 64000;
		endcase
	endfunction
	// latency in ns from unit code and count
	function automatic int lat_ns(input logic [1:0] code,
		input logic [4:0] cnt);
		lat_ns = (int'(cnt) + 1) * unit_ns(code);
	endfunction
	// resume to suspend gap in ns from its count
	function automatic int gap_ns(input logic [3:0] cnt);
		gap_ns = (int'(cnt) + 1) * INTERVAL_UNIT_NS;
	endfunction
endpackage

// file: verilog/work_counter.sv
`timescale 1ns/1ps
// remaining work of the array operation; holds whenever neither loaded nor advanced
module work_counter #(
	parameter int CNT_W = 24
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_value,
	input wire logic advance,
	output logic [CNT_W-1:0] remaining,
	output logic expired
);
	// zero work left
	assign expired = (remaining == '0);

	// load wins over advance; a held count is the resume point
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			remaining <= '0;
		end else if (load) begin
			remaining <= load_value;
		end else if (advance && !expired) begin
			remaining <= remaining - 1'b1;
		end
	end
endmodule // work_counter

// file: sim/host_model.sv
`timescale 1ns/1ps
// host side: starts and instructions, driven on falling edges
module host_model
	import susp_pkg::*;
#(
	parameter int GAP_NS = 128000 // resume to next suspend
) (
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic start_erase,
	output logic start_program,
	input wire logic ref_clk
);
	realtime last_resume = -1.0e9; // far past, first suspend not held
	// idle values; host never reads, so no suspended sector or page
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'hFF;
		start_erase = 1'b0;
		start_program = 1'b0;
	end
	// one-cycle instruction; a suspend first waits out the gap
	task automatic issue(input logic [7:0] code);
		while (code == CMD_SUSPEND && $realtime - last_resume < GAP_NS)
			@(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_code = code;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_code = ~code; // stale byte not left on the bus
		if (code == CMD_RESUME)
			last_resume = $realtime;
	endtask
	// one-cycle start pulse, erase or program
	task automatic start(input logic erase);
		@(negedge ref_clk);
		start_erase = erase;
		start_program = !erase;
		@(negedge ref_clk);
		start_erase = 1'b0;
		start_program = 1'b0;
	endtask
endmodule // host_model

// file: sim/flash_suspend_resume_params_test.sv
`timescale 1ns/1ps
// checks the parameter word and suspend, resume and refusal timing
module flash_suspend_resume_params_test;
	import susp_pkg::*;
	// short work lengths keep the run small
	localparam logic [23:0] ERS_N = 24'h000040;
	localparam logic [23:0] PGM_N = 24'h000030;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid, start_erase, start_program;
	logic [7:0] cmd_code;
	logic busy, erase_suspended, program_suspended, op_done;
	logic [31:0] param_word;
	logic [31:0] w; // copy of the word under test
	int n_errors = 0;
	int n_compared = 0;
	// free-running clock
	initial forever #4 ref_clk = ~ref_clk;
	suspend_ctrl #(.ERASE_CYCLES(ERS_N), .PROGRAM_CYCLES(PGM_N)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .start_erase(start_erase),
		.start_program(start_program), .busy(busy),
		.erase_suspended(erase_suspended),
		.program_suspended(program_suspended), .op_done(op_done),
		.param_word(param_word));
	host_model host (.cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.start_erase(start_erase), .start_program(start_program),
		.ref_clk(ref_clk));
	task automatic summarize;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic skip(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	// bounded wait for the done pulse
	task automatic wait_done(input int bound);
		int k;
		k = 0;
		while (op_done !== 1'b1) begin
			if (k == bound) begin
				$display("[ERR] %0t op_done missing", $time);
				n_errors++;
				summarize();
			end
			@(negedge ref_clk);
			k++;
		end
	endtask
	// suspend mid-run, refused start and code, resume, finish
	task automatic susp_resume(input logic ers, input int late, input int left);
		host.start(ers);
		skip(late);
		host.issue(CMD_SUSPEND);
		// flag rises 17 edges after the edge that takes the suspend
		skip(16);
		check({erase_suspended, program_suspended}, 32'h0);
		skip(1);
		check({erase_suspended, program_suspended}, {ers, !ers});
		host.start(!ers);
		host.issue(8'h00);
		check({busy, erase_suspended, program_suspended},
			{1'b1, ers, !ers});
		host.issue(CMD_RESUME);
		skip(1);
		check({erase_suspended, program_suspended}, 32'h0);
		wait_done(left);
		check(busy, 32'h0);
	endtask
	// main sequence
	initial begin
		skip(2);
		rst_b = 1'b1;
		skip(1);
		w = param_word;
		check(w, 32'h441883CC);
		check(w[31], 32'h0);
		check({w[30:29], w[19:18]}, 32'hA);
		check(32'((w[28:24] + 32'h1) * 8000), 32'h9C40);
		check(32'((w[17:13] + 32'h1) * 8000), 32'h9C40);
		check(32'((w[23:20] + 32'h1) * 64000), 32'h1F400);
		check(32'((w[12:9] + 32'h1) * 64000), 32'h1F400);
		check(w[8], 32'h1);
		check(w[7:4], 32'hC);
		check(w[3:0], 32'hC);
		// plain erase: done N+1 edges after the edge taking the start
		host.start(1'b1);
		skip(int'(ERS_N));
		check({busy, op_done}, 32'h2);
		skip(1);
		check({busy, op_done}, 32'h1);
		// suspend while idle is ignored
		host.issue(CMD_SUSPEND);
		skip(20);
		check({busy, erase_suspended, program_suspended}, 32'h0);
		// restart would need the full count, so bounds are tight
		susp_resume(1'b1, 20, 50);
		// wait out the resume gap first, else the short work ends early
		skip(RESUME_GAP_MIN_NS / CLK_PERIOD_NS);
		susp_resume(1'b0, 10, 44);
		check(param_word, w);
		summarize();
	end
endmodule // flash_suspend_resume_params_test
